// ==== hw/lfs_pkg.sv ====
// Package for the link-layer frame segmenter: header layouts, codes, sizes.
// Assumes one 40 MHz clock domain and an AXI4-Lite register master.
package lfs_pkg;
  // ----------------------------------------
  // Frame header layout
  // ----------------------------------------
  localparam logic [2:0] LFS_FT_PAD = 3'h0;
  localparam logic [2:0] LFS_FT_MGMT = 3'h1;
  localparam logic [2:0] LFS_FT_DATA = 3'h2;
  localparam logic [2:0] LFS_FT_NULL = 3'h3;
  localparam logic [2:0] LFS_PRIO_MGMT = 3'h7;
  localparam logic [7:0] LFS_SRC_XDOMAIN = 8'hfb;
  localparam logic [7:0] LFS_TGT_RESERVED_DA = 8'h00;
  localparam logic [47:0] LFS_RESERVED_DA = 48'h0119a7527696;
  localparam logic [3:0] LFS_HDR_LEN_SHORT = 4'h6;
  localparam logic [3:0] LFS_HDR_LEN_LONG = 4'ha;
  localparam logic [5:0] LFS_HOP_ZERO = 6'h00;
  localparam logic [5:0] LFS_HOP_ONE = 6'h01;
  // ----------------------------------------
  // Segment unit layout
  // ----------------------------------------
  localparam logic [2:0] LFS_SEGHDR_LEN = 3'h4;
  localparam logic [2:0] LFS_CRC_LEN = 3'h4;
  localparam logic [9:0] LFS_LFBO_NONE = 10'h3ff;
  localparam logic [10:0] LFS_FEC_DEFAULT = 11'h21c;
  localparam logic [31:0] LFS_CRC_POLY = 32'h8ddb6f41;
  localparam logic [31:0] LFS_CRC_INIT = 32'hffffffff;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] LFS_REG_CTRL = 8'h00;
  localparam logic [7:0] LFS_REG_NODE = 8'h04;
  localparam logic [7:0] LFS_REG_FEC = 8'h08;
  localparam logic [7:0] LFS_REG_STAT = 8'h0c;
  localparam logic [7:0] LFS_REG_SSN = 8'h10;
  localparam logic [1:0] LFS_RESP_OKAY = 2'h0;
  localparam logic [1:0] LFS_RESP_SLVERR = 2'h2;
  localparam logic [15:0] LFS_SSN_START = 16'h0000;

  // Frame request descriptor from the client side
  typedef struct packed {
    logic is_mgmt;
    logic is_relay;
    logic ts_present;
    logic cipher_present;
    logic [2:0] user_prio;
    logic prio_assigned;
    logic [13:0] body_length;
    logic inter_domain;
    logic [7:0] relay_src;
    logic broadcast;
    logic multicast;
    logic [7:0] dest_id;
    logic [47:0] dest_mac;
    logic [5:0] hop_limit;
    logic [31:0] timestamp;
  } lfs_frame_req_t;

  // Byte on the MAC side
  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic last;
  } lfs_mac_byte_t;

  typedef enum logic [1:0] {LFS_OKAY, LFS_RSVD, LFS_SLVERR, LFS_DECERR} lfs_unused_t;
endpackage : lfs_pkg

// ==== hw/lfs_segmenter.sv ====
// Frame header builder and segmenter with CRC trailer.
// Assumes client bytes and MAC byte sink on aclk; AXI4-Lite master for setup.
`timescale 1ns/1ps
module lfs_segmenter (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Frame request and body bytes
  input wire lfs_pkg::lfs_frame_req_t frm_req,
  input wire logic frm_valid,
  output logic frm_ready,
  input wire logic [7:0] body_data,
  input wire logic body_valid,
  output logic body_ready,
  input wire logic blk_end,
  // MAC byte stream
  output lfs_pkg::lfs_mac_byte_t mac_byte,
  output logic mac_valid,
  input wire logic mac_ready
);
  import lfs_pkg::*;

  typedef enum {ST_IDLE, ST_SHDR, ST_HDR, ST_BODY, ST_PAD, ST_CRC} lfs_state_t;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic enable_q, mgmt_block_q, mix_ok_q;
  logic [7:0] node_id_q, all_nodes_q;
  logic [10:0] fec_q;
  logic [15:0] ssn_q;
  logic [15:0] drop_cnt_q;
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic busy;
  logic drop_pulse;

  // Address and data may arrive in either order; hold until both present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= LFS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q[7:2] <= LFS_REG_SSN[7:2]) ? LFS_RESP_OKAY : LFS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready outputs registered so each channel is taken once per write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_got_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Register writes; segment size locked while a block is in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= 1'b0;
      mgmt_block_q <= 1'b0;
      mix_ok_q <= 1'b0;
      node_id_q <= 8'h00;
      all_nodes_q <= 8'hff;
      fec_q <= LFS_FEC_DEFAULT;
    end else if (aw_got_q && w_got_q && !s_axi_bvalid) begin
      if (awaddr_q == LFS_REG_CTRL && s_axi_wstrb[0]) begin
        enable_q <= wdata_q[0];
        mgmt_block_q <= wdata_q[1];
        mix_ok_q <= wdata_q[2];
      end
      if (awaddr_q == LFS_REG_NODE && s_axi_wstrb[0]) node_id_q <= wdata_q[7:0];
      if (awaddr_q == LFS_REG_NODE && s_axi_wstrb[1]) all_nodes_q <= wdata_q[15:8];
      if (awaddr_q == LFS_REG_FEC && !busy) fec_q <= wdata_q[10:0];
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= LFS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= LFS_RESP_OKAY;
        case (s_axi_araddr)
          LFS_REG_CTRL: s_axi_rdata <= {29'h0, mix_ok_q, mgmt_block_q, enable_q};
          LFS_REG_NODE: s_axi_rdata <= {16'h0, all_nodes_q, node_id_q};
          LFS_REG_FEC: s_axi_rdata <= {21'h0, fec_q};
          LFS_REG_STAT: s_axi_rdata <= {drop_cnt_q, 15'h0, busy};
          LFS_REG_SSN: s_axi_rdata <= {16'h0, ssn_q};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= LFS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Header builder
  // ----------------------------------------
  logic [79:0] hdr_c;
  logic [3:0] hdr_len_c;
  logic [7:0] tgt_c, src_c;
  logic [2:0] prio_c;
  logic [5:0] hop_c;
  logic drop_c, mix_bad_c;

  always_comb begin
    // Priority: management fixed, data from classifier or zero
    prio_c = frm_req.is_mgmt ? LFS_PRIO_MGMT :
             (frm_req.prio_assigned ? frm_req.user_prio : 3'h0);
    // Source id kept by relays, else own or cross-domain marker
    src_c = frm_req.is_relay ? frm_req.relay_src :
            (frm_req.inter_domain ? LFS_SRC_XDOMAIN : node_id_q);
    // Target selection by delivery kind
    if (frm_req.is_relay) tgt_c = frm_req.dest_id;
    else if (frm_req.dest_mac == LFS_RESERVED_DA) tgt_c = LFS_TGT_RESERVED_DA;
    else if (frm_req.broadcast) tgt_c = all_nodes_q;
    else tgt_c = frm_req.dest_id;
    hop_c = (frm_req.is_relay) ? frm_req.hop_limit - LFS_HOP_ONE : frm_req.hop_limit;
    drop_c = frm_req.is_relay && frm_req.hop_limit == LFS_HOP_ZERO;
    // Mixing refused unless control bit 2 (mix_ok_q) is set
    mix_bad_c = !mix_ok_q && (frm_req.is_mgmt != mgmt_block_q);
    hdr_len_c = frm_req.ts_present ? LFS_HDR_LEN_LONG : LFS_HDR_LEN_SHORT;
    // Octet 0 in bits 7:0, reserved bits zero
    hdr_c = {frm_req.timestamp[31:24], frm_req.timestamp[23:16], frm_req.timestamp[15:8],
             frm_req.timestamp[7:0],
             hop_c, 1'b0, frm_req.broadcast && !frm_req.multicast, tgt_c, src_c,
             1'b0, frm_req.multicast, frm_req.body_length,
             prio_c, frm_req.cipher_present, frm_req.ts_present,
             frm_req.is_mgmt ? LFS_FT_MGMT : LFS_FT_DATA};
  end

  // ----------------------------------------
  // Segmenter state machine
  // ----------------------------------------
  lfs_state_t st_q;
  logic [79:0] hdr_q;
  logic [3:0] hdr_len_q, hdr_idx_q;
  logic [13:0] body_left_q;
  logic [10:0] seg_pos_q, seg_size_q;
  logic [1:0] idx4_q;
  logic [31:0] shdr_q, crc_q;
  logic frame_open_q, blk_end_q, lfbo_set_q;
  logic [9:0] lfbo_q;
  logic take, fire, seg_full;
  logic [7:0] out_c;
  logic [31:0] crc_next;
  logic [13:0] rem_c;
  logic [9:0] lfbo_c;

  assign busy = st_q != ST_IDLE;
  // A byte is committed when the output register is empty or being emptied
  assign fire = st_q != ST_IDLE && (st_q != ST_BODY || body_valid) && (!mac_valid || mac_ready);
  assign seg_full = seg_pos_q == seg_size_q - 11'h1;
  assign take = frm_valid && frm_ready;

  // Frame bytes still owed; a boundary exists only if they end inside the next segment
  assign rem_c = body_left_q + {10'h0, hdr_len_q - hdr_idx_q};
  assign lfbo_c = (rem_c < {3'h0, seg_size_q}) ? rem_c[9:0] : LFS_LFBO_NONE;

  // Bitwise CRC update, bytes fed LSB first
  always_comb begin
    crc_next = crc_q;
    for (int i = 0; i < 8; i++) begin
      crc_next = (crc_next[31] ^ out_c[i]) ? {crc_next[30:0], 1'b0} ^ LFS_CRC_POLY
                                           : {crc_next[30:0], 1'b0};
    end
  end

  // Next output byte by state
  always_comb begin
    case (st_q)
      ST_SHDR: out_c = shdr_q[8*idx4_q +: 8];
      ST_HDR: out_c = hdr_q[8*hdr_idx_q +: 8];
      ST_BODY: out_c = body_data;
      ST_PAD: out_c = 8'h00;
      ST_CRC: out_c = ~crc_q[31 - 8*idx4_q -: 8];
      default: out_c = 8'h00;
    endcase
  end

  // Segment sequencing: header, payload bytes, CRC trailer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      hdr_q <= 80'h0;
      hdr_len_q <= 4'h0;
      hdr_idx_q <= 4'h0;
      body_left_q <= 14'h0;
      seg_pos_q <= 11'h0;
      seg_size_q <= 11'h0;
      idx4_q <= 2'h0;
      shdr_q <= 32'h0;
      crc_q <= LFS_CRC_INIT;
      frame_open_q <= 1'b0;
      blk_end_q <= 1'b0;
      ssn_q <= LFS_SSN_START;
      drop_cnt_q <= 16'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (take && !(drop_c || mix_bad_c)) begin
            seg_size_q <= fec_q - {8'h0, LFS_SEGHDR_LEN} - {8'h0, LFS_CRC_LEN};
            hdr_q <= hdr_c;
            hdr_len_q <= hdr_len_c;
            hdr_idx_q <= 4'h0;
            body_left_q <= frm_req.body_length;
            frame_open_q <= 1'b1;
            blk_end_q <= 1'b0;
            shdr_q <= {3'h0, 1'b1, mgmt_block_q && !mix_ok_q, 1'b1, 10'h0, ssn_q};
            idx4_q <= 2'h0;
            crc_q <= LFS_CRC_INIT;
            st_q <= ST_SHDR;
          end else if (take) begin
            drop_cnt_q <= drop_cnt_q + 16'h1;
          end
        end
        ST_SHDR: if (fire) begin
          crc_q <= crc_next;
          idx4_q <= idx4_q + 2'h1;
          if (idx4_q == 2'h3) begin
            seg_pos_q <= 11'h0;
            st_q <= frame_open_q ? (hdr_idx_q < hdr_len_q ? ST_HDR : ST_BODY) : ST_PAD;
          end
        end
        ST_HDR, ST_BODY, ST_PAD: if (fire) begin
          crc_q <= crc_next;
          seg_pos_q <= seg_pos_q + 11'h1;
          if (st_q == ST_HDR) begin
            hdr_idx_q <= hdr_idx_q + 4'h1;
            if (hdr_idx_q == hdr_len_q - 4'h1) st_q <= ST_BODY;
          end else if (st_q == ST_BODY) begin
            body_left_q <= body_left_q - 14'h1;
            if (body_left_q == 14'h1) frame_open_q <= 1'b0;
          end
          if (seg_full) begin
            idx4_q <= 2'h0;
            st_q <= ST_CRC;
          end else if (st_q == ST_BODY && body_left_q == 14'h1) begin
            st_q <= ST_PAD;
          end
        end
        ST_CRC: if (fire) begin
          idx4_q <= idx4_q + 2'h1;
          if (idx4_q == 2'h3) begin
            ssn_q <= ssn_q + 16'h1;
            crc_q <= LFS_CRC_INIT;
            if (frame_open_q) begin
              // Trailing segment: valid, not oldest, boundary where the frame ends
              shdr_q <= {3'h0, 1'b0, mgmt_block_q && !mix_ok_q, 1'b1, lfbo_c,
                         ssn_q + 16'h1};
              st_q <= ST_SHDR;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Frame accept only when idle and enabled; one frame per pass keeps order
  always_ff @(posedge aclk) begin
    if (!aresetn) frm_ready <= 1'b0;
    else frm_ready <= enable_q && st_q == ST_IDLE && !frm_ready;
  end

  // Body bytes pass straight through in arrival order
  always_comb begin
    body_ready = st_q == ST_BODY && fire;
  end

  // MAC output register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mac_byte <= '0;
      mac_valid <= 1'b0;
    end else begin
      // Load only on commit so a stalled byte is never shown twice
      if (fire) begin
        mac_valid <= 1'b1;
        mac_byte <= '{data: out_c, first: st_q == ST_SHDR && idx4_q == 2'h0,
                      last: st_q == ST_CRC && idx4_q == 2'h3};
      end else if (mac_ready) begin
        mac_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  mac_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mac_valid && !mac_ready |=> mac_valid && $stable(mac_byte))
    else $error("MAC byte changed while stalled");
  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  mgmt_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
    take && frm_req.is_mgmt |-> hdr_c[7:5] == LFS_PRIO_MGMT)
    else $error("management frame priority not seven");
  seg_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == ST_HDR || st_q == ST_BODY || st_q == ST_PAD) |-> seg_pos_q < seg_size_q)
    else $error("segment position beyond segment size");
  fec_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    busy |=> $stable(fec_q))
    else $error("segment size changed during a block");
  hop_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    take && drop_c |=> st_q == ST_IDLE)
    else $error("frame with no hops left was relayed");
endmodule : lfs_segmenter

// ==== tb/lfs_mac_sink.sv ====
// MAC-side byte sink with random back-pressure; reports each byte taken.
// Assumes the segmenter's registered byte stream on aclk.
`timescale 1ns/1ps
module lfs_mac_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire lfs_pkg::lfs_mac_byte_t mac_byte,
  input wire logic mac_valid,
  output logic mac_ready,
  output logic got,
  output lfs_pkg::lfs_mac_byte_t got_byte
);
  import lfs_pkg::*;
  // ----------------------------------------
  // Back-pressure and capture
  // ----------------------------------------
  // Stall about one cycle in four so held bytes get exercised
  always_ff @(posedge aclk) begin
    mac_ready <= aresetn && ($urandom_range(3) != 0);
    got <= aresetn && mac_valid && mac_ready;
    got_byte <= mac_byte;
  end
endmodule : lfs_mac_sink

// ==== tb/testbench.sv ====
// Bench for the frame segmenter: register setup, frame table, masked unit byte check with CRC bytes not compared.
// Assumes lfs_pkg, lfs_segmenter and lfs_mac_sink are compiled first.
`timescale 1ns/1ps
module testbench;
  import lfs_pkg::*;
  // Short FEC block keeps frames spanning several segments
  localparam int FEC = 32;
  localparam int SEG = FEC - LFS_SEGHDR_LEN - LFS_CRC_LEN;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, frm_valid, frm_ready, body_valid, body_ready;
  logic blk_end, mac_valid, mac_ready, got;
  logic [7:0] awaddr, araddr, body_data;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [9:0] e, m;
  logic [9:0] exp_q[$];
  logic [9:0] msk_q[$];
  logic [15:0] ssn;
  lfs_frame_req_t frm_req;
  lfs_mac_byte_t mac_byte, got_byte;
  int fail_count, checked, cycles;

  lfs_segmenter u_lfs_segmenter (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .frm_req(frm_req), .frm_valid(frm_valid),
    .frm_ready(frm_ready), .body_data(body_data), .body_valid(body_valid),
    .body_ready(body_ready), .blk_end(blk_end), .mac_byte(mac_byte),
    .mac_valid(mac_valid), .mac_ready(mac_ready));
  lfs_mac_sink u_lfs_mac_sink (.aclk(aclk), .aresetn(aresetn), .mac_byte(mac_byte),
    .mac_valid(mac_valid), .mac_ready(mac_ready), .got(got), .got_byte(got_byte));

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic cmp_reg(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask : cmp_reg

  task automatic cmp_byte(input string n, input logic [9:0] x, input logic [9:0] g);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask : cmp_byte

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    r = bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    v = rdata;
    r = rresp;
  endtask : axi_rd

  // ----------------------------------------
  // Frame stimulus and expected segment units
  // ----------------------------------------
  // Flags: 0 mgmt, 1 relay, 2 stamp, 3 prio given, 4 xdomain, 5 bcast, 6 mcast, 7 rsvd DA
  function automatic lfs_frame_req_t mk(input logic [7:0] fl, input logic [2:0] pr,
      input logic [13:0] len, input logic [7:0] dst, input logic [5:0] hop);
    lfs_frame_req_t r;
    r = '0;
    {r.dest_mac[0], r.multicast, r.broadcast, r.inter_domain} = fl[7:4];
    {r.prio_assigned, r.ts_present, r.is_relay, r.is_mgmt} = fl[3:0];
    r.dest_mac = fl[7] ? LFS_RESERVED_DA : 48'h020000000001;
    r.user_prio = pr;
    r.body_length = len;
    r.dest_id = dst;
    r.hop_limit = hop;
    r.relay_src = 8'h5a;
    r.timestamp = $urandom();
    return r;
  endfunction : mk

  task automatic put(input logic [7:0] v, input logic [7:0] mk8, input logic f, input logic l);
    exp_q.push_back({v, f, l});
    msk_q.push_back({mk8, 2'h3});
  endtask : put

  task automatic run_frame(input lfs_frame_req_t r, input logic [2:0] ctrl);
    logic [7:0] f[$];
    logic [7:0] b[$];
    logic [9:0] bo;
    int n, s, k;
    axi_wr(LFS_REG_CTRL, {29'h0, ctrl}, rs);
    for (k = 0; k < r.body_length; k++) b.push_back(8'($urandom()));
    f.push_back({r.is_mgmt ? LFS_PRIO_MGMT : (r.prio_assigned ? r.user_prio : 3'h0),
      1'h0, r.ts_present, r.is_mgmt ? LFS_FT_MGMT : LFS_FT_DATA});
    f.push_back(r.body_length[7:0]);
    f.push_back({1'h0, r.multicast, r.body_length[13:8]});
    f.push_back(r.is_relay ? r.relay_src : (r.inter_domain ? LFS_SRC_XDOMAIN : 8'h21));
    f.push_back(r.dest_mac == LFS_RESERVED_DA ? LFS_TGT_RESERVED_DA :
      (r.broadcast ? 8'hfe : r.dest_id));
    f.push_back({r.is_relay ? r.hop_limit - LFS_HOP_ONE : r.hop_limit, 1'h0, r.broadcast});
    for (k = 0; k < 4 && r.ts_present; k++) f.push_back(r.timestamp[8*k+:8]);
    f = {f, b};
    n = f.size();
    // A relayed frame arriving with no hops left produces nothing
    for (s = 0; s * SEG < n && !(r.is_relay && r.hop_limit == LFS_HOP_ZERO); s++) begin
      bo = (s == 0) ? 10'h0 : ((s + 1) * SEG > n ? 10'(n - s * SEG) : LFS_LFBO_NONE);
      put(ssn[7:0], 8'hff, 1'h1, 1'h0);
      put(ssn[15:8], 8'hff, 1'h0, 1'h0);
      put(bo[7:0], 8'hff, 1'h0, 1'h0);
      put({4'h0, ctrl[1] & ~ctrl[2], 1'h1, bo[9:8]}, 8'hef, 1'h0, 1'h0);
      for (k = s * SEG; k < (s + 1) * SEG; k++) put(k < n ? f[k] : 8'h0, k <= n ? 8'hff : 8'h0,
        1'h0, 1'h0);
      for (k = 0; k < 4; k++) put(8'h0, 8'h0, 1'h0, k == 3);
      ssn++;
    end
    frm_req <= r;
    frm_valid <= 1'h1;
    do @(posedge aclk); while (frm_ready !== 1'h1);
    frm_valid <= 1'h0;
    foreach (b[i]) begin
      body_data <= b[i];
      body_valid <= 1'h1;
      do @(posedge aclk); while (body_ready !== 1'h1);
    end
    body_valid <= 1'h0;
    while (exp_q.size() != 0) @(posedge aclk);
    repeat (8) @(posedge aclk);
    $display("test frame done, next sequence %0d", ssn);
  endtask : run_frame

  // ----------------------------------------
  // Clock, output watcher, timeout
  // ----------------------------------------
  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  // Each accepted byte is matched against the oldest note
  always @(posedge aclk) begin
    if (got && exp_q.size() == 0) begin
      fail_count++;
      $display("MISMATCH mac_byte expected none seen %h", got_byte);
    end else if (got) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      cmp_byte("mac_byte", e & m, 10'(got_byte) & m);
    end
  end

  // A hang ends in the same verdict path
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      $display("MISMATCH timeout expected done seen hang");
      wrap_up();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, frm_valid, body_valid} = '0;
    {awaddr, araddr, body_data, wdata} = '0;
    {blk_end, frm_req, ssn, fail_count, checked, cycles} = '0;
    wstrb = 4'hf;
    void'($urandom(32'h5efb));
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    axi_rd(LFS_REG_FEC, d, rs);
    cmp_reg("fec_reset", 32'h21c, d);
    axi_rd(LFS_REG_NODE, d, rs);
    cmp_reg("node_reset", 32'hff00, d);
    axi_rd(8'h14, d, rs);
    cmp_reg("unmapped_resp", 32'(LFS_RESP_SLVERR), 32'(rs));
    axi_wr(LFS_REG_FEC, 32'(FEC), rs);
    cmp_reg("fec_wr_resp", 32'(LFS_RESP_OKAY), 32'(rs));
    axi_wr(LFS_REG_NODE, 32'hfe21, rs);
    $display("test registers done");
    run_frame(mk(8'h0c, 3'h5, 14'h1e, 8'h33, 6'h09), 3'h1);
    run_frame(mk(8'h30, 3'h6, 14'h12, 8'h33, 6'h09), 3'h1);
    run_frame(mk(8'h49, 3'h2, 14'h32, 8'h44, 6'h03), 3'h3);
    run_frame(mk(8'h01, 3'h0, 14'h05, 8'h55, 6'h03), 3'h7);
    run_frame(mk(8'h0a, 3'h2, 14'h0a, 8'h12, 6'h04), 3'h1);
    run_frame(mk(8'h0a, 3'h2, 14'h00, 8'h12, 6'h00), 3'h1);
    run_frame(mk(8'h88, 3'h1, 14'h01, 8'h77, 6'h01), 3'h1);
    axi_rd(LFS_REG_STAT, d, rs);
    cmp_reg("stat_drops", 32'h10000, d);
    wrap_up();
  end
endmodule : testbench
